// File: hw/tsp_pkg.sv
/*
 * Package for the trap status and priority control block: register offsets,
 * bit positions, reset values and the event carrier struct.
 * Assumes a 32-bit classic Wishbone bus with byte addresses.
 */
package tsp_pkg;

  localparam logic [7:0] TSP_OFS_CORE_CTRL  = 8'h00;
  localparam logic [7:0] TSP_OFS_TRAP_CTRL  = 8'h04;
  localparam logic [7:0] TSP_OFS_CPU_STATUS = 8'h08;
  localparam logic [7:0] TSP_OFS_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] TSP_OFS_IRQ_MASK   = 8'h10;

  // Trap control and status layout
  localparam int TSP_NESTING_DISABLE_BIT  = 15;
  localparam int TSP_OVA_FLAG    = 14;
  localparam int TSP_OVB_FLAG    = 13;
  localparam int TSP_COVA_FLAG   = 12;
  localparam int TSP_COVB_FLAG   = 11;
  localparam int TSP_OVA_EN      = 10;
  localparam int TSP_OVB_EN      = 9;
  localparam int TSP_COV_EN      = 8;
  localparam int TSP_SHIFT_FLAG  = 7;
  localparam int TSP_DIV0_FLAG   = 6;
  localparam int TSP_MATH_FLAG   = 4;
  localparam int TSP_ADDR_FLAG   = 3;
  localparam int TSP_STACK_FLAG  = 2;
  localparam int TSP_OSC_FLAG    = 1;

  // Sticky flags cleared by writing zero; enables plain read/write
  localparam logic [15:0] TSP_TRAP_FLAG_MASK = 16'h78de;
  localparam logic [15:0] TSP_TRAP_RW_MASK   = 16'h8700;
  localparam logic [15:0] TSP_TRAP_RESET     = 16'h0000;

  // Core control: priority MSB at bit 3
  localparam int          TSP_PRIO_MSB_BIT   = 3;
  localparam logic [15:0] TSP_CORE_RESET     = 16'h0000;

  // CPU status register field for the low priority bits
  localparam int TSP_PRIO_LOW_LSB = 5;
  localparam int TSP_PRIO_LOW_W   = 3;
  localparam logic [2:0] TSP_PRIO_LOW_RESET = 3'h0;
  localparam logic [3:0] TSP_PRIO_SEVEN     = 4'h7;

  // Interrupt status bits
  localparam int TSP_IRQ_W = 8;
  localparam int TSP_IRQ_OVA   = 0;
  localparam int TSP_IRQ_OVB   = 1;
  localparam int TSP_IRQ_COVA  = 2;
  localparam int TSP_IRQ_COVB  = 3;
  localparam int TSP_IRQ_SHIFT = 4;
  localparam int TSP_IRQ_DIV0  = 5;
  localparam int TSP_IRQ_ADDR  = 6;
  localparam int TSP_IRQ_STK   = 7;

  typedef struct packed {
    logic acc_a_overflow;
    logic acc_b_overflow;
    logic acc_a_catastrophic;
    logic acc_b_catastrophic;
    logic bad_shift;
    logic divide_zero;
    logic address_error;
    logic stack_error;
    logic osc_fail;
  } tsp_event_type;

  typedef struct packed {
    logic       user_irq_disable;
    logic       nesting_allowed;
    logic [3:0] cpu_priority;
  } tsp_prio_type;

endpackage : tsp_pkg

// File: hw/tsp_trap_ctrl.sv
/*
 * Trap status and priority control: trap flags, overflow trap enables,
 * nesting disable, CPU priority level and an event interrupt.
 * Assumes trap events are one-cycle pulses synchronous to clk_sys, and that
 * the exception sequencer raises the priority MSB when it takes a trap.
 */
// Contract
// RULE_01 - Priority MSB at core control bit 3 is one when priority exceeds 7.
// RULE_02 - CPU priority is MSB above the three low status-register bits.
// RULE_03 - Nesting disable bit 15 set forbids nesting; clear allows it.
// RULE_04 - Bit 14 flags accumulator A overflow trap, bit 13 accumulator B.
// RULE_05 - Bit 12 flags catastrophic A overflow, bit 11 catastrophic B.
// RULE_06 - Overflow traps for A and B need enables bit 10 and 9.
// RULE_07 - Catastrophic overflow trap needs enable bit 8.
// RULE_08 - Bit 7 set by math trap from invalid accumulator shift.
// RULE_09 - Bit 6 set by math trap from division by zero.
// RULE_10 - Bit 4 set on any math error trap.
// RULE_11 - Bit 3 set on address error trap.
// RULE_12 - Bit 2 set on stack error trap.
// RULE_13 - Bit 1 set on oscillator failure trap.
// RULE_14 - Bits 5 and 0 read zero and ignore writes.
// RULE_15 - Software can never set the priority MSB.
// RULE_16 - All user interrupts disabled while priority MSB is one.
// RULE_17 - Low priority bits read-only while nesting is disabled.
// RULE_18 - Trap flags stay set until software writes zero.
// RULE_19 - Priority MSB clearable by software, zero after reset.
`timescale 1ns/1ps
module tsp_trap_ctrl
  import tsp_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          arst_n,
  input  wire logic          clk_en,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  output logic               wb_err_o,
  input  wire tsp_event_type trap_event,
  input  wire logic          trap_taken,
  output tsp_prio_type       prio_out,
  output logic               trap_pending,
  output logic               irq
);

  logic [15:0]          trap_reg;
  logic                 prio_msb_reg;
  logic [2:0]           prio_low_reg;
  logic [TSP_IRQ_W-1:0] irq_status_reg;
  logic [TSP_IRQ_W-1:0] irq_mask_reg;
  logic                 ack_reg;
  logic [31:0]          rdata_reg;
  logic                 err_reg;

  logic        req;
  logic        wr;
  logic        lo_lane;
  logic        hi_lane;
  logic        hit;
  logic [15:0] wmask;
  logic [15:0] trap_set;
  logic        ova_trap;
  logic        ovb_trap;
  logic        cova_trap;
  logic        covb_trap;
  logic        math_trap;
  logic [TSP_IRQ_W-1:0] irq_set;

  // One-wait-state slave: request taken while no ack is out
  assign req     = wb_cyc_i && wb_stb_i && !ack_reg && clk_en;
  assign wr      = req && wb_we_i;
  assign lo_lane = wb_sel_i[0];
  assign hi_lane = wb_sel_i[1];
  assign wmask   = {{8{hi_lane}}, {8{lo_lane}}};
  assign hit     = (wb_adr_i == TSP_OFS_CORE_CTRL) || (wb_adr_i == TSP_OFS_TRAP_CTRL) ||
                   (wb_adr_i == TSP_OFS_CPU_STATUS) || (wb_adr_i == TSP_OFS_IRQ_STATUS) ||
                   (wb_adr_i == TSP_OFS_IRQ_MASK);

  // Traps gated by their enables
  assign ova_trap  = trap_event.acc_a_overflow && trap_reg[TSP_OVA_EN];          // RULE_06
  assign ovb_trap  = trap_event.acc_b_overflow && trap_reg[TSP_OVB_EN];          // RULE_06
  assign cova_trap = trap_event.acc_a_catastrophic && trap_reg[TSP_COV_EN];      // RULE_07
  assign covb_trap = trap_event.acc_b_catastrophic && trap_reg[TSP_COV_EN];      // RULE_07
  assign math_trap = ova_trap || ovb_trap || cova_trap || covb_trap ||
                     trap_event.bad_shift || trap_event.divide_zero;             // RULE_10

  always_comb begin
    trap_set = 16'h0000;
    trap_set[TSP_OVA_FLAG]   = ova_trap;                                          // RULE_04
    trap_set[TSP_OVB_FLAG]   = ovb_trap;                                          // RULE_04
    trap_set[TSP_COVA_FLAG]  = cova_trap;                                         // RULE_05
    trap_set[TSP_COVB_FLAG]  = covb_trap;                                         // RULE_05
    trap_set[TSP_SHIFT_FLAG] = trap_event.bad_shift;                              // RULE_08
    trap_set[TSP_DIV0_FLAG]  = trap_event.divide_zero;                            // RULE_09
    trap_set[TSP_MATH_FLAG]  = math_trap;                                         // RULE_10
    trap_set[TSP_ADDR_FLAG]  = trap_event.address_error;                          // RULE_11
    trap_set[TSP_STACK_FLAG] = trap_event.stack_error;                            // RULE_12
    trap_set[TSP_OSC_FLAG]   = trap_event.osc_fail;                               // RULE_13
  end

  // Flags: a write of zero clears, a same-cycle event wins over the clear
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      trap_reg <= TSP_TRAP_RESET;
    end else if (clk_en) begin
      if (wr && wb_adr_i == TSP_OFS_TRAP_CTRL) begin
        trap_reg <= ((trap_reg & ~wmask) | (wb_dat_i[15:0] & wmask & TSP_TRAP_RW_MASK) |
                     (trap_reg & wmask & wb_dat_i[15:0] & TSP_TRAP_FLAG_MASK)
                     & (TSP_TRAP_RW_MASK | TSP_TRAP_FLAG_MASK))                    // RULE_14
                    | trap_set;                                                   // RULE_18
      end else begin
        trap_reg <= trap_reg | trap_set;                                          // RULE_18
      end
    end
  end

  // Priority MSB: sequencer sets it on trap entry; software may only clear it
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prio_msb_reg <= 1'b0;                                                       // RULE_19
    end else if (clk_en) begin
      if (trap_taken) begin
        prio_msb_reg <= 1'b1;
      end else if (wr && lo_lane && wb_adr_i == TSP_OFS_CORE_CTRL &&
                   !wb_dat_i[TSP_PRIO_MSB_BIT]) begin
        prio_msb_reg <= 1'b0;                                                     // RULE_15
      end
    end
  end

  // Low priority bits writable only while nesting is enabled
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prio_low_reg <= TSP_PRIO_LOW_RESET;
    end else if (clk_en) begin
      if (wr && lo_lane && wb_adr_i == TSP_OFS_CPU_STATUS && !trap_reg[TSP_NESTING_DISABLE_BIT]) begin
        prio_low_reg <= wb_dat_i[TSP_PRIO_LOW_LSB +: TSP_PRIO_LOW_W];             // RULE_17
      end
    end
  end

  always_comb begin
    irq_set = '0;
    irq_set[TSP_IRQ_OVA]   = ova_trap;
    irq_set[TSP_IRQ_OVB]   = ovb_trap;
    irq_set[TSP_IRQ_COVA]  = cova_trap;
    irq_set[TSP_IRQ_COVB]  = covb_trap;
    irq_set[TSP_IRQ_SHIFT] = trap_event.bad_shift;
    irq_set[TSP_IRQ_DIV0]  = trap_event.divide_zero;
    irq_set[TSP_IRQ_ADDR]  = trap_event.address_error;
    irq_set[TSP_IRQ_STK]   = trap_event.stack_error;
  end

  // Write-one-to-clear status; set wins over clear
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_status_reg <= '0;
    end else if (clk_en) begin
      if (wr && lo_lane && wb_adr_i == TSP_OFS_IRQ_STATUS) begin
        irq_status_reg <= (irq_status_reg & ~wb_dat_i[TSP_IRQ_W-1:0]) | irq_set;
      end else begin
        irq_status_reg <= irq_status_reg | irq_set;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_mask_reg <= '0;
    end else if (clk_en && wr && lo_lane && wb_adr_i == TSP_OFS_IRQ_MASK) begin
      irq_mask_reg <= wb_dat_i[TSP_IRQ_W-1:0];
    end
  end

  // Bus answer: ack or err one cycle after the request, read data registered
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ack_reg   <= 1'b0;
      err_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else if (clk_en) begin
      ack_reg   <= req && hit;
      err_reg   <= req && !hit;
      rdata_reg <= 32'h0000_0000;
      if (req && !wb_we_i) begin
        case (wb_adr_i)
          TSP_OFS_CORE_CTRL: begin
            rdata_reg[TSP_PRIO_MSB_BIT] <= prio_msb_reg;                          // RULE_01
          end
          TSP_OFS_TRAP_CTRL: begin
            rdata_reg[15:0] <= trap_reg & (TSP_TRAP_RW_MASK | TSP_TRAP_FLAG_MASK); // RULE_14
          end
          TSP_OFS_CPU_STATUS: begin
            rdata_reg[TSP_PRIO_LOW_LSB +: TSP_PRIO_LOW_W] <= prio_low_reg;
          end
          TSP_OFS_IRQ_STATUS: begin
            rdata_reg[TSP_IRQ_W-1:0] <= irq_status_reg;
          end
          TSP_OFS_IRQ_MASK: begin
            rdata_reg[TSP_IRQ_W-1:0] <= irq_mask_reg;
          end
          default: begin
            rdata_reg <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_err_o = err_reg;
  assign wb_dat_o = rdata_reg;

  assign prio_out.cpu_priority     = {prio_msb_reg, prio_low_reg};               // RULE_02
  assign prio_out.user_irq_disable = prio_msb_reg;                                // RULE_16
  assign prio_out.nesting_allowed  = !trap_reg[TSP_NESTING_DISABLE_BIT];                   // RULE_03
  assign trap_pending = |(trap_reg & TSP_TRAP_FLAG_MASK);
  assign irq          = |(irq_status_reg & irq_mask_reg);

  // Checks
  msb_means_above7_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    prio_out.user_irq_disable == (prio_out.cpu_priority > TSP_PRIO_SEVEN))       // RULE_01
    else $error("priority msb disagrees with level");
  prio_concat_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    prio_out.cpu_priority[2:0] == prio_low_reg)                                  // RULE_02
    else $error("low priority bits wrong");
  nest_ctrl_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    prio_out.nesting_allowed != trap_reg[TSP_NESTING_DISABLE_BIT])                        // RULE_03
    else $error("nesting control wrong");
  ova_flag_set_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    clk_en && trap_event.acc_a_overflow && trap_reg[TSP_OVA_EN]
    |=> trap_reg[TSP_OVA_FLAG] && trap_reg[TSP_MATH_FLAG])                        // RULE_04
    else $error("overflow A flag not set");
  ova_disabled_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    clk_en && !trap_reg[TSP_OVA_EN] && !wr && !$past(trap_reg[TSP_OVA_FLAG])
    && !trap_reg[TSP_OVA_FLAG] |=> !trap_reg[TSP_OVA_FLAG])                       // RULE_06
    else $error("disabled overflow A trap flagged");
  cov_flag_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    clk_en && trap_event.acc_b_catastrophic && trap_reg[TSP_COV_EN]
    |=> trap_reg[TSP_COVB_FLAG])                                                  // RULE_07
    else $error("catastrophic B flag not set");
  div0_math_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    clk_en && trap_event.divide_zero |=> trap_reg[TSP_DIV0_FLAG] && trap_reg[TSP_MATH_FLAG]) // RULE_09
    else $error("divide flag not set");
  unimpl_zero_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    trap_reg[5] == 1'b0 && trap_reg[0] == 1'b0)                                  // RULE_14
    else $error("unimplemented bit set");
  flag_sticky_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    trap_reg[TSP_OSC_FLAG] && !(wr && wb_adr_i == TSP_OFS_TRAP_CTRL) |=> trap_reg[TSP_OSC_FLAG]) // RULE_18
    else $error("flag lost without write");
  msb_no_sw_set_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !prio_msb_reg && !trap_taken |=> !prio_msb_reg)                               // RULE_15
    else $error("priority msb set without trap");
  low_locked_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    trap_reg[TSP_NESTING_DISABLE_BIT] |=> prio_low_reg == $past(prio_low_reg))             // RULE_17
    else $error("low priority changed while locked");
  bus_ack_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    req && hit |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack timing wrong");

  trap_seen_c: cover property (@(posedge clk_sys) disable iff (!arst_n) trap_taken ##1 prio_msb_reg);
  irq_fire_c:  cover property (@(posedge clk_sys) disable iff (!arst_n) $rose(irq));
  clear_race_c: cover property (@(posedge clk_sys) disable iff (!arst_n)
    wr && wb_adr_i == TSP_OFS_TRAP_CTRL && |trap_set);

endmodule // tsp_trap_ctrl

// File: testbench/tsp_core_model.sv
/*
 * Core-side model: trap sources and exception sequencer, pulsing trap
 * events and trap_taken for exactly one cycle on command.
 * Assumes the bench raises fire for one cycle, just after a rising edge.
 */
`timescale 1ns/1ps
module tsp_core_model
  import tsp_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          arst_n,
  input  wire logic          fire,
  input  wire tsp_event_type ev_req,
  input  wire logic          take_req,
  output tsp_event_type      trap_event,
  output logic               trap_taken
);
  // Registered copy of fire, so a pulse lasts as many cycles as fire is held high
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      trap_event <= '0;
      trap_taken <= 1'b0;
    end else begin
      trap_event <= fire ? ev_req : '0;
      trap_taken <= fire & take_req;
    end
  end
endmodule // tsp_core_model

// File: testbench/test_trap_status_and_priority_ctrl.sv
/*
 * Self-checking bench: register reset values, access kinds, trap flags,
 * priority level, nesting lock and the event interrupt.
 * Assumes tsp_pkg, tsp_trap_ctrl and tsp_core_model are compiled first.
 */
`timescale 1ns/1ps
module test_trap_status_and_priority_ctrl
  import tsp_pkg::*;
;
  logic          clk_sys, arst_n, cyc, stb, we, ack, err, fire, take, pend, irq;
  logic [7:0]    adr;
  logic [31:0]   dat, rdat, q;
  tsp_event_type ev, trap_event;
  tsp_prio_type  prio;
  logic          trap_taken, last_err, ce;
  logic [2:0]    en;
  logic [7:0]    m, ie;
  logic [15:0]   f;
  int            errors, total_checks, seed, cycles;

  tsp_trap_ctrl u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err), .trap_event(trap_event), .trap_taken(trap_taken), .prio_out(prio),
    .trap_pending(pend), .irq(irq));
  tsp_core_model u_core (.clk_sys(clk_sys), .arst_n(arst_n), .fire(fire), .ev_req(ev), .take_req(take),
    .trap_event(trap_event), .trap_taken(trap_taken));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Hangs end in the common verdict
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 20000) begin
      errors++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // Classic cycle: hold until ack or err is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!(ack === 1'b1 || err === 1'b1) && n < 20);
    q = rdat;
    last_err = err;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  task automatic pulse(input tsp_event_type e, input logic t);
    @(posedge clk_sys);
    ev <= e; take <= t; fire <= 1'b1;
    @(posedge clk_sys);
    fire <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  function automatic logic [15:0] exp_flags(input logic [2:0] n, input tsp_event_type e);
    logic [15:0] r;
    r = 16'h0000;
    r[14] = e.acc_a_overflow & n[2];
    r[13] = e.acc_b_overflow & n[1];
    r[12] = e.acc_a_catastrophic & n[0];
    r[11] = e.acc_b_catastrophic & n[0];
    r[7] = e.bad_shift;
    r[6] = e.divide_zero;
    r[4] = |{r[14:11], r[7:6]};
    r[3] = e.address_error;
    r[2] = e.stack_error;
    r[1] = e.osc_fail;
    return r;
  endfunction

  initial begin
    seed = 52; errors = 0; total_checks = 0; cycles = 0;
    arst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; dat = 32'h0;
    fire = 1'b0; take = 1'b0; ev = '0; ce = 1'b1;
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(TSP_OFS_CORE_CTRL, 32'h0);
    rd(TSP_OFS_TRAP_CTRL, 32'h0);
    wb(1'b0, 8'h20, 32'h0);
    chk(last_err, 1'b1);
    $display("reset and map test done");
    wb(1'b1, TSP_OFS_TRAP_CTRL, 32'hffff);
    rd(TSP_OFS_TRAP_CTRL, 32'h8700);
    chk(prio.nesting_allowed, 1'b0);
    wb(1'b1, TSP_OFS_CPU_STATUS, 32'he0);
    rd(TSP_OFS_CPU_STATUS, 32'h0);
    wb(1'b1, TSP_OFS_TRAP_CTRL, 32'h0700);
    chk(prio.nesting_allowed, 1'b1);
    wb(1'b1, TSP_OFS_CPU_STATUS, 32'ha0);
    rd(TSP_OFS_CPU_STATUS, 32'ha0);
    wb(1'b1, TSP_OFS_CORE_CTRL, 32'h8);
    rd(TSP_OFS_CORE_CTRL, 32'h0);
    chk(prio.cpu_priority, 4'h5);
    chk(prio.user_irq_disable, 1'b0);
    pulse('0, 1'b1);
    rd(TSP_OFS_CORE_CTRL, 32'h8);
    chk(prio.cpu_priority, 4'hd);
    chk(prio.user_irq_disable, 1'b1);
    wb(1'b1, TSP_OFS_CORE_CTRL, 32'h0);
    rd(TSP_OFS_CORE_CTRL, 32'h0);
    $display("priority test done");
    // Frozen clock enable: a divide-by-zero event must leave no trace
    ce <= 1'b0;
    pulse(tsp_event_type'(9'h008), 1'b1);
    ce <= 1'b1;
    rd(TSP_OFS_TRAP_CTRL, 32'h0700);
    rd(TSP_OFS_IRQ_STATUS, 32'h0);
    rd(TSP_OFS_CORE_CTRL, 32'h0);
    $display("clock enable test done");
    for (int i = 0; i < 40; i++) begin
      en = $random(seed);
      m = $random(seed);
      // Each source alone in the first nine passes, then random mixes, each with random enables
      ev = (i < 9) ? tsp_event_type'(9'h100 >> i) : tsp_event_type'($random(seed));
      f = exp_flags(en, ev);
      ie = {f[2], f[3], f[6], f[7], f[11], f[12], f[13], f[14]};
      wb(1'b1, TSP_OFS_TRAP_CTRL, {21'h0, en, 8'h00});
      pulse(ev, 1'b0);
      rd(TSP_OFS_TRAP_CTRL, {16'h0, f} | {21'h0, en, 8'h00});
      chk(pend, |f);
      rd(TSP_OFS_IRQ_STATUS, {24'h0, ie});
      wb(1'b1, TSP_OFS_IRQ_MASK, {24'h0, m});
      @(posedge clk_sys);
      chk(irq, |(ie & m));
      wb(1'b1, TSP_OFS_TRAP_CTRL, {21'h0, en, 8'hde} | 32'h7800);
      rd(TSP_OFS_TRAP_CTRL, {16'h0, f} | {21'h0, en, 8'h00});
      wb(1'b1, TSP_OFS_TRAP_CTRL, {21'h0, en, 8'h00});
      rd(TSP_OFS_TRAP_CTRL, {21'h0, en, 8'h00});
      wb(1'b1, TSP_OFS_IRQ_STATUS, 32'hff);
      rd(TSP_OFS_IRQ_STATUS, 32'h0);
      @(posedge clk_sys);
      chk(irq, 1'b0);
    end
    $display("trap event test done");
    test_done();
  end
endmodule // test_trap_status_and_priority_ctrl
